// >>> bert_ctl_pkg.sv
// constants, field layouts and encodings for the bert trigger and gating block
package bert_ctl_pkg;

  // ****************************************************
  // register byte offsets
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_ELAPSED = 8'h10;
  localparam logic [7:0] ADDR_PROG_LEN = 8'h14;
  localparam logic [7:0] ADDR_PROG_BYTE = 8'h18;
  localparam logic [7:0] ADDR_PROG_BIT = 8'h1c;
  localparam logic [7:0] ADDR_INTERVALS = 8'h20;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int TRIG_LSB = 0;
  localparam int BUZZ_LSB = 3;
  localparam int MODE_LSB = 5;
  localparam int TXPAT_LSB = 7;
  localparam int RXPAT_LSB = 9;
  localparam int PAY_LSB = 11;
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;
  localparam int DAY_LSB = 24;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int BYTE_IDX_LSB = 8;
  localparam int BIT_IDX_LSB = 8;

  // ****************************************************
  // encodings
  // ****************************************************
  typedef enum logic [2:0] {
    TRIG_TX_DIV16 = 3'h0, TRIG_TX_DIV64 = 3'h1, TRIG_TX_PATT = 3'h2,
    TRIG_TX_ERR = 3'h3, TRIG_RX_DIV16 = 3'h4, TRIG_RX_DIV64 = 3'h5,
    TRIG_RX_PATT = 3'h6, TRIG_RX_ERR = 3'h7
  } trig_sel_t;
  typedef enum logic [1:0] {
    PAT_PRBS = 2'h0, PAT_SHORT = 2'h1, PAT_LONG = 2'h2, PAT_FRAME = 2'h3
  } pattern_t;
  typedef enum logic [2:0] {
    PAY_PRBS9 = 3'h0, PAY_PRBS10 = 3'h1, PAY_PRBS11 = 3'h2,
    PAY_PRBS15 = 3'h3, PAY_PRBS23 = 3'h4, PAY_PRBS31 = 3'h5
  } payload_t;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0, MODE_MANUAL = 2'h1, MODE_REPEAT = 2'h2
  } mode_t;
  typedef enum logic [1:0] {
    BUZZ_OFF = 2'h0, BUZZ_SOFT = 2'h1, BUZZ_MEDIUM = 2'h2, BUZZ_LOUD = 2'h3
  } buzz_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} gate_state_t;

  // ****************************************************
  // reset values and counts
  // ****************************************************
  localparam logic [4:0] RESET_HOURS = 5'h00;
  localparam logic [5:0] RESET_MINUTES = 6'h00;
  localparam logic [5:0] RESET_SECONDS = 6'h01;
  localparam logic [3:0] RESET_DAYS = 4'h0;
  localparam logic [8:0] PROG_MIN_LEN = 9'h010;
  localparam logic [8:0] PROG_MAX_LEN = 9'h100;
  localparam logic [8:0] RESET_PROG_LEN = PROG_MIN_LEN;
  localparam int DIV16_BIT = 3;
  localparam int DIV64_BIT = 5;
  localparam logic [6:0] PATT_LAST = 7'h7f;
  localparam logic [3:0] MAX_DAYS = 4'ha;
  localparam logic [4:0] MAX_HOUR = 5'h17;
  localparam logic [5:0] MAX_MIN_SEC = 6'h3b;
  localparam int SEC_PER_DAY = 86400;
  localparam int SEC_PER_HOUR = 3600;
  localparam int SEC_PER_MIN = 60;
  localparam logic [19:0] MAX_SECONDS = 20'hd2f00;
  localparam int SECOND_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SECOND_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;

endpackage : bert_ctl_pkg

// >>> bert_trigger_gate.sv
// trigger selector, payload select, program memory and measurement gating
`timescale 1ns/10ps
module bert_trigger_gate #(
  parameter int unsigned SECOND_CYCLES = bert_ctl_pkg::SECOND_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic tx_clk_i,
  input wire logic rx_clk_i,
  input wire logic tx_err_i,
  input wire logic rx_err_i,
  input wire logic tx_pattern_start_i,
  input wire logic rx_pattern_start_i,
  input wire logic [7:0] prog_addr_i,
  output logic prog_bit_o,
  output logic trigger_o,
  output bert_ctl_pkg::payload_t payload_prbs_o,
  output logic payload_enable_o,
  output bert_ctl_pkg::buzz_t buzzer_level_o,
  output logic buzz_o,
  output logic measuring_o,
  output logic interval_end_o
);
  import bert_ctl_pkg::*;

  if (SECOND_CYCLES < 2 || SECOND_CYCLES > 32'h07ffffff) begin : g_bad_cycles
    $error("SECOND_CYCLES out of range");
  end

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [19:0] to_seconds(input logic [3:0] d,
      input logic [4:0] h, input logic [5:0] m, input logic [5:0] s);
    to_seconds = 20'(20'(d) * 20'(SEC_PER_DAY)) +
                 20'(20'(h) * 20'(SEC_PER_HOUR)) +
                 20'(20'(m) * 20'(SEC_PER_MIN)) + 20'(s);
  endfunction : to_seconds

  function automatic logic rising(input logic [2:0] s, input logic lvl);
    rising = (s[1] == s[2]) && s[2] && !lvl;
  endfunction : rising

  // ****************************************************
  // configuration state
  // ****************************************************
  trig_sel_t trig_sel;
  buzz_t buzz_sel;
  mode_t mode;
  pattern_t tx_pat;
  pattern_t rx_pat;
  payload_t payload;
  logic [3:0] days;
  logic [4:0] hours;
  logic [5:0] minutes;
  logic [5:0] seconds;
  logic [8:0] prog_len;
  logic [4:0] byte_idx;
  logic [7:0] prog_mem [32];

  // ****************************************************
  // bus decode
  // ****************************************************
  wire bus_req = cyc_i && stb_i && !ack_o;
  wire full_wr = bus_req && we_i && (sel_i == 4'hf);
  wire wr_ctrl = full_wr && (adr_i == ADDR_CTRL);
  wire wr_cmd = full_wr && (adr_i == ADDR_CMD);
  wire wr_period = full_wr && (adr_i == ADDR_PERIOD);
  wire wr_status = full_wr && (adr_i == ADDR_STATUS);
  wire wr_len = full_wr && (adr_i == ADDR_PROG_LEN);
  wire wr_byte = full_wr && (adr_i == ADDR_PROG_BYTE);
  wire wr_bit = full_wr && (adr_i == ADDR_PROG_BIT);
  wire start_cmd = wr_cmd && dat_i[CMD_START_BIT];
  wire stop_cmd = wr_cmd && dat_i[CMD_STOP_BIT];
  wire [1:0] w_mode = dat_i[MODE_LSB+:2];
  wire [2:0] w_pay = dat_i[PAY_LSB+:3];
  wire w_mode_ok = (w_mode != 2'h3);
  wire w_pay_ok = (w_pay <= PAY_PRBS31);
  wire [3:0] w_day = dat_i[DAY_LSB+:4];
  wire [4:0] w_hour = dat_i[HOUR_LSB+:5];
  wire [5:0] w_min = dat_i[MIN_LSB+:6];
  wire [5:0] w_sec = dat_i[SEC_LSB+:6];
  wire [19:0] w_total = to_seconds(w_day, w_hour, w_min, w_sec);
  // out-of-range periods are refused whole, so no half-valid h:m:s exists
  wire w_period_ok = (w_day <= MAX_DAYS) && (w_hour <= MAX_HOUR) &&
                     (w_min <= MAX_MIN_SEC) && (w_sec <= MAX_MIN_SEC) &&
                     (w_total != 20'h0) && (w_total <= MAX_SECONDS);
  wire [8:0] w_len = dat_i[8:0];
  wire w_len_ok = (w_len >= PROG_MIN_LEN) && (w_len <= PROG_MAX_LEN);
  wire [4:0] w_byte_idx = dat_i[BYTE_IDX_LSB+:5];
  wire [7:0] w_bit_idx = dat_i[BIT_IDX_LSB+:8];

  // ****************************************************
  // configuration registers
  // ****************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_sel <= TRIG_TX_DIV16;
      buzz_sel <= BUZZ_OFF;
      mode <= MODE_SINGLE;
      tx_pat <= PAT_PRBS;
      rx_pat <= PAT_PRBS;
      payload <= PAY_PRBS9;
    end else if (wr_ctrl) begin
      // separate pattern registers for each side: tx_pat and rx_pat can be set apart
      trig_sel <= trig_sel_t'(dat_i[TRIG_LSB+:3]);
      buzz_sel <= buzz_t'(dat_i[BUZZ_LSB+:2]);
      tx_pat <= pattern_t'(dat_i[TXPAT_LSB+:2]);
      rx_pat <= pattern_t'(dat_i[RXPAT_LSB+:2]);
      if (w_mode_ok) begin
        mode <= mode_t'(w_mode[1:0]);
      end
      if (w_pay_ok) begin
        payload <= payload_t'(w_pay);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      days <= RESET_DAYS;
      hours <= RESET_HOURS;
      minutes <= RESET_MINUTES;
      seconds <= RESET_SECONDS;
      prog_len <= RESET_PROG_LEN;
    end else begin
      if (wr_period && w_period_ok) begin
        days <= w_day;
        hours <= w_hour;
        minutes <= w_min;
        seconds <= w_sec;
      end
      if (wr_len && w_len_ok) begin
        prog_len <= w_len;
      end
    end
  end

  // ****************************************************
  // short program pattern memory
  // ****************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_idx <= 5'h00;
    end else if (wr_byte) begin
      byte_idx <= w_byte_idx;
    end
  end

  // memory content is not reset; software loads it before use
  always_ff @(posedge clk_i) begin
    if (wr_byte) begin
      prog_mem[w_byte_idx] <= dat_i[7:0];
    end else if (wr_bit) begin
      prog_mem[w_bit_idx[7:3]][w_bit_idx[2:0]] <= dat_i[0];
    end
  end

  // generator wraps its address at prog_len; the length is read back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_bit_o <= 1'b0;
    end else begin
      prog_bit_o <= prog_mem[prog_addr_i[7:3]][prog_addr_i[2:0]];
    end
  end

  // ****************************************************
  // bit clock inputs
  // ****************************************************
  logic [2:0] tx_sync;
  logic [2:0] rx_sync;
  logic tx_lvl;
  logic rx_lvl;
  logic [6:0] tx_cnt;
  logic [6:0] rx_cnt;
  wire tx_rise = rising(tx_sync, tx_lvl);
  wire rx_rise = rising(rx_sync, rx_lvl);
  // bit clocks must stay well below a quarter of clk_i to be seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sync <= 3'h0;
      rx_sync <= 3'h0;
      tx_lvl <= 1'b0;
      rx_lvl <= 1'b0;
      tx_cnt <= 7'h00;
      rx_cnt <= 7'h00;
    end else begin
      tx_sync <= {tx_sync[1:0], tx_clk_i};
      rx_sync <= {rx_sync[1:0], rx_clk_i};
      if (tx_sync[1] == tx_sync[2]) begin
        tx_lvl <= tx_sync[2];
      end
      if (rx_sync[1] == rx_sync[2]) begin
        rx_lvl <= rx_sync[2];
      end
      if (tx_rise) begin
        tx_cnt <= tx_cnt + 7'h01;
      end
      if (rx_rise) begin
        rx_cnt <= rx_cnt + 7'h01;
      end
    end
  end

  // ****************************************************
  // trigger selection
  // ****************************************************
  wire tx_patt = (tx_pat == PAT_PRBS) ? (tx_rise && tx_cnt == PATT_LAST)
                                      : tx_pattern_start_i;
  wire rx_patt = (rx_pat == PAT_PRBS) ? (rx_rise && rx_cnt == PATT_LAST)
                                      : rx_pattern_start_i;
  logic next_trigger;

  always_comb begin
    unique case (trig_sel)
      TRIG_TX_DIV16: next_trigger = tx_cnt[DIV16_BIT];
      TRIG_TX_DIV64: next_trigger = tx_cnt[DIV64_BIT];
      TRIG_TX_PATT: next_trigger = tx_patt;
      TRIG_TX_ERR: next_trigger = tx_err_i;
      TRIG_RX_DIV16: next_trigger = rx_cnt[DIV16_BIT];
      TRIG_RX_DIV64: next_trigger = rx_cnt[DIV64_BIT];
      TRIG_RX_PATT: next_trigger = rx_patt;
      TRIG_RX_ERR: next_trigger = rx_err_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_o <= 1'b0;
      payload_prbs_o <= PAY_PRBS9;
      payload_enable_o <= 1'b0;
      buzzer_level_o <= BUZZ_OFF;
      buzz_o <= 1'b0;
    end else begin
      trigger_o <= next_trigger;
      payload_enable_o <= (tx_pat == PAT_FRAME);
      payload_prbs_o <= (tx_pat == PAT_FRAME) ? payload : PAY_PRBS9;
      buzzer_level_o <= buzz_sel;
      buzz_o <= rx_err_i && (buzz_sel != BUZZ_OFF);
    end
  end

  // ****************************************************
  // measurement gating
  // ****************************************************
  gate_state_t state;
  gate_state_t next_state;
  logic [26:0] tick_cnt;
  logic [19:0] elapsed;
  logic [15:0] intervals;
  logic done;
  wire sec_tick = (state == ST_RUN) && (tick_cnt == 27'(SECOND_CYCLES - 1));
  wire [19:0] elapsed_inc = elapsed + 20'h1;
  wire [19:0] period_sec = to_seconds(days, hours, minutes, seconds);
  wire [19:0] limit = (mode == MODE_MANUAL) ? MAX_SECONDS
                                            : period_sec;
  wire reached = sec_tick && (elapsed_inc >= limit);
  wire rollover = reached && (mode == MODE_REPEAT);
  wire finish = (state == ST_RUN) && (stop_cmd || (reached && !rollover));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_cmd) next_state = ST_RUN;
      ST_RUN: if (finish) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      measuring_o <= 1'b0;
      interval_end_o <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      measuring_o <= (next_state == ST_RUN);
      interval_end_o <= rollover && !stop_cmd;
      // a finish in the clearing cycle is kept: set beats clear
      if (finish) begin
        done <= 1'b1;
      end else if ((wr_status && dat_i[STAT_DONE_BIT]) || start_cmd) begin
        done <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= 27'h0;
      elapsed <= 20'h0;
      intervals <= 16'h0;
    end else if (state == ST_IDLE && start_cmd) begin
      tick_cnt <= 27'h0;
      elapsed <= 20'h0;
      intervals <= 16'h0;
    end else if (state == ST_RUN) begin
      tick_cnt <= sec_tick ? 27'h0 : tick_cnt + 27'h1;
      if (rollover) begin
        elapsed <= 20'h0;
        intervals <= intervals + 16'h1;
      end else if (sec_tick) begin
        elapsed <= elapsed_inc;
      end
    end
  end

  // ****************************************************
  // bus read and acknowledge
  // ****************************************************
  wire [31:0] rd_ctrl = {18'h0, payload, rx_pat, tx_pat, mode, buzz_sel,
                         trig_sel};
  wire [31:0] rd_period = {4'h0, days, 3'h0, hours, 2'h0, minutes, 2'h0,
                           seconds};
  wire [31:0] rd_data =
    (adr_i == ADDR_CTRL) ? rd_ctrl :
    (adr_i == ADDR_PERIOD) ? rd_period :
    (adr_i == ADDR_STATUS) ? {30'h0, done, state == ST_RUN} :
    (adr_i == ADDR_ELAPSED) ? {12'h0, elapsed} :
    (adr_i == ADDR_PROG_LEN) ? {23'h0, prog_len} :
    (adr_i == ADDR_PROG_BYTE) ? {19'h0, byte_idx, prog_mem[byte_idx]} :
    (adr_i == ADDR_INTERVALS) ? {16'h0, intervals} : 32'h0;

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= rd_data;
      end
    end
  end

endmodule : bert_trigger_gate

// >>> bert_trigger_gate_props.sv
// checker of bus, buzzer, payload and gating relations at the ports
`timescale 1ns/10ps
module bert_trigger_gate_props
  import bert_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic rx_err_i,
  input wire logic buzz_o,
  input wire bert_ctl_pkg::buzz_t buzzer_level_o,
  input wire bert_ctl_pkg::payload_t payload_prbs_o,
  input wire logic payload_enable_o,
  input wire logic measuring_o,
  input wire logic interval_end_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack pulse wrong");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_buzz_on;
    rx_err_i && buzzer_level_o != BUZZ_OFF |=> buzz_o;
  endproperty
  a_buzz_on: assert property (p_buzz_on)
    else $error("buzzer silent on error");
  property p_buzz_cause;
    buzz_o |-> $past(rx_err_i) && $past(buzzer_level_o) != BUZZ_OFF;
  endproperty
  a_buzz_cause: assert property (p_buzz_cause)
    else $error("buzzer without cause");
  property p_pay_idle;
    !payload_enable_o |-> payload_prbs_o == PAY_PRBS9;
  endproperty
  a_pay_idle: assert property (p_pay_idle)
    else $error("payload code outside frame");
  property p_pay_range;
    payload_prbs_o <= PAY_PRBS31;
  endproperty
  a_pay_range: assert property (p_pay_range)
    else $error("payload code out of range");
  // start only through an acknowledged command write
  property p_meas_start;
    $rose(measuring_o) |->
      $past(cyc_i && stb_i && !ack_o && we_i && adr_i == ADDR_CMD &&
            dat_i[CMD_START_BIT]);
  endproperty
  a_meas_start: assert property (p_meas_start)
    else $error("measurement began without start");
  property p_intv;
    interval_end_o |-> measuring_o ##1 !interval_end_o;
  endproperty
  a_intv: assert property (p_intv)
    else $error("interval end pulse wrong");
  c_intv: cover property (interval_end_o);
  c_buzz: cover property (buzz_o);
  c_stop: cover property ($fell(measuring_o));
endmodule : bert_trigger_gate_props

bind bert_trigger_gate bert_trigger_gate_props i_props (.clk_i, .rst_i,
  .adr_i, .dat_i, .we_i, .cyc_i, .stb_i, .ack_o, .rx_err_i, .buzz_o,
  .buzzer_level_o, .payload_prbs_o, .payload_enable_o, .measuring_o,
  .interval_end_o);

// >>> bert_stream_model.sv
// free-running transmit and receive bit clocks of the stream under test
`timescale 1ns/10ps
module bert_stream_model #(
  parameter int TX_HALF_NS = 50,
  parameter int RX_HALF_NS = 70
) (
  output logic tx_clk_o,
  output logic rx_clk_o
);
  // bit clocks run free; slow enough for the block's edge synchronisers
  initial begin
    tx_clk_o = 1'b0;
    forever #(TX_HALF_NS) tx_clk_o = ~tx_clk_o;
  end
  // rate unrelated to tx so a swapped source shows up
  initial begin
    rx_clk_o = 1'b0;
    forever #(RX_HALF_NS) rx_clk_o = ~rx_clk_o;
  end
endmodule : bert_stream_model

// >>> bert_trigger_gate_bench.sv
// bench: bus, trigger sources, buzzer, payload, program memory, gating
`timescale 1ns/10ps
module bert_trigger_gate_bench;
  import bert_ctl_pkg::*;
  // ****************
  // signals
  // ****************
  localparam int SC = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'hf;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic tx_err_i = 1'b0;
  logic rx_err_i = 1'b0;
  logic tx_ps = 1'b0;
  logic rx_ps = 1'b0;
  logic [7:0] prog_addr_i = 8'h00;
  logic tx_clk, rx_clk, ack_o, prog_bit_o, trigger_o, payload_enable_o;
  logic buzz_o, measuring_o, interval_end_o;
  logic [31:0] dat_o;
  payload_t payload_prbs_o;
  buzz_t buzzer_level_o;
  logic [1:0] blv = 2'h0;
  int n_errors = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int seed = 99;
  logic [31:0] exq[$];
  logic [31:0] bad[5] = '{32'h0a000001, 32'h0b000000, 32'h0,
    32'h00180000, 32'h0000003c};

  always #5 clk_i = ~clk_i;

  bert_stream_model i_far (.tx_clk_o(tx_clk), .rx_clk_o(rx_clk));
  bert_trigger_gate #(.SECOND_CYCLES(SC)) i_dut (.clk_i, .rst_i, .adr_i,
    .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .tx_clk_i(tx_clk),
    .rx_clk_i(rx_clk), .tx_err_i, .rx_err_i, .tx_pattern_start_i(tx_ps),
    .rx_pattern_start_i(rx_ps), .prog_addr_i, .prog_bit_o, .trigger_o,
    .payload_prbs_o, .payload_enable_o, .buzzer_level_o, .buzz_o,
    .measuring_o, .interval_end_o);

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // the expected word is queued before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask : rd

  function automatic logic [31:0] ctl(input logic [2:0] t,
      input logic [1:0] b, input logic [1:0] m, input logic [1:0] p,
      input logic [2:0] y);
    return {18'h0, y, p, p, m, b, t};
  endfunction : ctl

  // waits for a rising edge of trigger_o, or interval_end_o when w is set
  task automatic rise(input logic w, output int t);
    logic p;
    int n;
    n = 0;
    do begin
      p = w ? interval_end_o : trigger_o;
      @(posedge clk_i);
      n++;
    end while (!(p === 1'b0 && (w ? interval_end_o : trigger_o) === 1'b1)
               && n < 3000);
    if (n >= 3000) n_errors++;
    t = cyc_cnt;
  endtask : rise

  task automatic pulse(input logic tx, input logic rx, input logic e);
    tx_err_i <= tx;
    rx_err_i <= rx;
    tx_ps <= tx;
    rx_ps <= rx;
    @(posedge clk_i);
    tx_err_i <= 1'b0;
    rx_err_i <= 1'b0;
    tx_ps <= 1'b0;
    rx_ps <= 1'b0;
    // look mid-cycle, once the registered trigger has settled
    @(negedge clk_i);
    chk(trigger_o, e);
    if (rx) chk(buzz_o, blv != 2'h0);
    @(posedge clk_i);
  endtask : pulse

  // ****************
  // checking and sequence
  // ****************
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
      chk(dat_o, exq.pop_front());

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    int t0, t1, t2, n, e;
    logic [7:0] b, ix;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_PERIOD, 32'h1);
    rd(ADDR_PROG_LEN, 32'h10);
    rd(8'h30, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wb(ADDR_CTRL, 1'b1, ctl(s[2:0], 2'h0, 2'h0, 2'h0, 3'h0));
      rd(ADDR_CTRL, {29'h0, s[2:0]});
      if (s % 4 == 3) begin
        pulse(s < 4 ? 1'b0 : 1'b1, s < 4 ? 1'b1 : 1'b0, 1'b0);
        pulse(s < 4 ? 1'b1 : 1'b0, s < 4 ? 1'b0 : 1'b1, 1'b1);
      end else begin
        e = (s > 3 ? 14 : 10) * (s % 4 == 0 ? 16 : s % 4 == 1 ? 64 : 128);
        rise(1'b0, t0);
        rise(1'b0, t1);
        rise(1'b0, t2);
        chk(t2 - t1, e);
      end
    end
    // non-prbs patterns: pattern sources follow the pattern start inputs
    for (int s = 2; s < 8; s += 4) begin
      wb(ADDR_CTRL, 1'b1, ctl(s[2:0], 2'h0, 2'h0, 2'h1, 3'h0));
      pulse(s > 3, s < 4, 1'b0);
      pulse(s < 4, s > 3, 1'b1);
    end
    for (int lv = 0; lv < 4; lv++) begin
      blv = lv[1:0];
      wb(ADDR_CTRL, 1'b1, ctl(3'h7, lv[1:0], 2'h0, 2'h0, 3'h0));
      chk(buzzer_level_o, lv[1:0]);
      pulse(1'b0, 1'b1, 1'b1);
    end
    for (int y = 0; y < 7; y++) begin
      wb(ADDR_CTRL, 1'b1, ctl(3'h0, 2'h0, 2'h0, 2'h3, y[2:0]));
      // code 6 is refused, so the previous code 5 stays
      chk({payload_enable_o, payload_prbs_o},
          {1'b1, (y > 5) ? 3'h5 : y[2:0]});
      wb(ADDR_CTRL, 1'b1, ctl(3'h0, 2'h0, 2'h0, 2'(y % 3), y[2:0]));
      chk({payload_enable_o, payload_prbs_o}, 4'h0);
    end
    b = 8'($random(seed));
    ix = {3'h0, 5'($random(seed))};
    wb(ADDR_PROG_BYTE, 1'b1, {19'h0, ix[4:0], b});
    rd(ADDR_PROG_BYTE, {19'h0, ix[4:0], b});
    wb(ADDR_PROG_BIT, 1'b1, {16'h0, ix[4:0], 3'h5, 7'h0, ~b[5]});
    for (int k = 0; k < 8; k++) begin
      prog_addr_i <= {ix[4:0], k[2:0]};
      repeat (2) @(posedge clk_i);
      chk(prog_bit_o, b[k] ^ (k == 5));
    end
    wb(ADDR_PROG_LEN, 1'b1, 32'h100);
    wb(ADDR_PROG_LEN, 1'b1, 32'h101);
    wb(ADDR_PROG_LEN, 1'b1, 32'h00f);
    rd(ADDR_PROG_LEN, 32'h100);
    wb(ADDR_PERIOD, 1'b1, 32'h09173b3b);
    foreach (bad[i]) wb(ADDR_PERIOD, 1'b1, bad[i]);
    sel_i <= 4'h1;
    wb(ADDR_PERIOD, 1'b1, 32'h1);
    sel_i <= 4'hf;
    rd(ADDR_PERIOD, 32'h09173b3b);
    wb(ADDR_PERIOD, 1'b1, 32'h0a000000);
    rd(ADDR_PERIOD, 32'h0a000000);
    wb(ADDR_PERIOD, 1'b1, 32'h2);
    wb(ADDR_CTRL, 1'b1, ctl(3'h0, 2'h0, 2'h0, 2'h0, 3'h0));
    wb(ADDR_CMD, 1'b1, 32'h1);
    n = 0;
    while (measuring_o === 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    // high for 2 seconds of SC cycles from the taking edge; wb returns two edges later
    chk(n, 2 * SC - 1);
    rd(ADDR_STATUS, 32'h2);
    wb(ADDR_PERIOD, 1'b1, 32'h1);
    wb(ADDR_CTRL, 1'b1, ctl(3'h0, 2'h0, 2'h2, 2'h0, 3'h0));
    wb(ADDR_CMD, 1'b1, 32'h1);
    rise(1'b1, t0);
    rise(1'b1, t1);
    rise(1'b1, t2);
    chk(t2 - t1, SC);
    wb(ADDR_CMD, 1'b1, 32'h2);
    chk(measuring_o, 1'b0);
    wb(ADDR_CTRL, 1'b1, ctl(3'h0, 2'h0, 2'h1, 2'h0, 3'h0));
    wb(ADDR_CMD, 1'b1, 32'h1);
    repeat (5 * SC) @(posedge clk_i);
    chk(measuring_o, 1'b1);
    wb(ADDR_CMD, 1'b1, 32'h2);
    chk(measuring_o, 1'b0);
    rd(ADDR_STATUS, 32'h2);
    print_verdict();
  end
endmodule : bert_trigger_gate_bench
